//--- bench/dcw_ctrl_model.sv
// Controller model that delivers the command word of each cyclic telegram
module dcw_ctrl_model (
    input  wire logic        i_ref_clk,
    output logic             o_word_valid,
    output logic [15:0]      o_word
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_word_valid = 1'b0;
        o_word       = 16'h5a5a;
    end

    // Command word goes out as the first process data word of a telegram
    task automatic send(input logic [15:0] w, input bit raw);
        logic [15:0] v;
        v = raw ? w : (w & 16'hecff); // Unused bits 8, 9, 12 driven low
        @(negedge i_ref_clk);
        o_word_valid = 1'b1;
        o_word       = v;
        @(negedge i_ref_clk);
        o_word_valid = 1'b0;
        // Released data must not look like the last word
        o_word       = ~v;
    endtask
endmodule // dcw_ctrl_model

//--- bench/test_dcw_decoder.sv
// Self-checking testbench of the drive command word decoder
module test_dcw_decoder;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   i_ref_clk;
    logic                   i_rst_n;
    logic                   i_word_valid;
    logic [15:0]            i_word;
    logic                   i_tlg20;
    logic                   i_fault;
    logic                   i_standstill;
    dcw_pkg::dcw_state_t    o_drive_state;
    logic                   o_pulse_en;
    dcw_pkg::dcw_rfg_ctrl_t o_rfg;
    logic                   o_sp_invert;
    dcw_pkg::dcw_mop_t      o_mop;
    logic                   o_cds_sel;
    logic                   o_fault_ack;
    logic                   o_remote_ctrl;
    logic [15:0]            o_received_word_bits;
    int                     failures;
    int                     checks_done;
    int                     acks;

    dcw_ctrl_model i_dcw_ctrl_model (
        .i_ref_clk    (i_ref_clk),
        .o_word_valid (i_word_valid),
        .o_word       (i_word)
    );

    dcw_decoder i_dcw_decoder (
        .i_ref_clk            (i_ref_clk),
        .i_rst_n              (i_rst_n),
        .i_word_valid         (i_word_valid),
        .i_word               (i_word),
        .i_tlg20              (i_tlg20),
        .i_fault              (i_fault),
        .i_standstill         (i_standstill),
        .o_drive_state        (o_drive_state),
        .o_pulse_en           (o_pulse_en),
        .o_rfg                (o_rfg),
        .o_sp_invert          (o_sp_invert),
        .o_mop                (o_mop),
        .o_cds_sel            (o_cds_sel),
        .o_fault_ack          (o_fault_ack),
        .o_remote_ctrl        (o_remote_ctrl),
        .o_received_word_bits (o_received_word_bits)
    );

    initial
    begin
        i_ref_clk = 1'b0;
    end

    always #5 i_ref_clk = ~i_ref_clk;

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic chk_drive(input dcw_pkg::dcw_state_t s, input logic p);
        chk({13'h0000, o_drive_state}, {13'h0000, s}, "state");
        chk({15'h0000, o_pulse_en}, {15'h0000, p}, "pulse");
    endtask

    task automatic chk_rfg(input dcw_pkg::dcw_ramp_t r, input logic z, input logic f);
        chk({12'h000, o_rfg}, {12'h000, r, z, f}, "ramp");
    endtask

    // Sends one word, then watches long enough for every answer to land
    task automatic put(input logic [15:0] w, input bit raw = 1'b0);
        acks = 0;
        i_dcw_ctrl_model.send(w, raw);
        repeat (4)
        begin
            if (o_fault_ack === 1'b1)
                acks++;
            @(negedge i_ref_clk);
        end
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        give_verdict();
    end

    initial
    begin
        i_rst_n      = 1'b0;
        // Telegram 20 from reset: bits 13/14 have no earlier use to keep
        i_tlg20      = 1'b1;
        i_fault      = 1'b0;
        i_standstill = 1'b0;
        failures     = 0;
        checks_done  = 0;
        acks         = 0;
        wait_cycles(6);
        chk_drive(dcw_pkg::DCW_S_INHIBIT, 1'b0);
        chk_rfg(dcw_pkg::DCW_RAMP_HOLD, 1'b1, 1'b0);
        chk(o_received_word_bits, 16'h0000, "reset word");
        chk({10'h000, o_sp_invert, o_mop, o_cds_sel, o_fault_ack, o_remote_ctrl}, 16'h0000, "reset");
        i_rst_n = 1'b1;
        $display("Test reset done");

        put(16'h007f);
        chk(o_received_word_bits, 16'h0000, "ignored word");
        chk_drive(dcw_pkg::DCW_S_INHIBIT, 1'b0);
        put(16'h6400);
        chk({14'h0000, o_mop}, 16'h0000, "mop unmapped");
        i_tlg20 = 1'b0;
        $display("Test remote done");

        for (int k = 1; k <= 2; k++)
        begin
            put(16'h040e & ~(16'h0001 << k));
            chk_drive(dcw_pkg::DCW_S_INHIBIT, 1'b0);
            put(16'h040f & ~(16'h0001 << k));
            chk_drive(dcw_pkg::DCW_S_INHIBIT, 1'b0);
        end
        $display("Test switch-on guard done");

        put(16'h040e);
        chk({15'h0000, o_remote_ctrl}, 16'h0001, "remote");
        chk_drive(dcw_pkg::DCW_S_READY_ON, 1'b0);
        put(16'h040b);
        chk_drive(dcw_pkg::DCW_S_READY_ON, 1'b0);
        put(16'h040e);
        put(16'h047f);
        chk_drive(dcw_pkg::DCW_S_RUN, 1'b1);
        chk_rfg(dcw_pkg::DCW_RAMP_UP, 1'b0, 1'b0);
        put(16'h045f);
        chk_rfg(dcw_pkg::DCW_RAMP_UP, 1'b0, 1'b1);
        put(16'h043f);
        chk_rfg(dcw_pkg::DCW_RAMP_DOWN, 1'b0, 1'b0);
        put(16'h046f);
        chk({15'h0000, o_rfg.zero}, 16'h0001, "zero");
        $display("Test ramp done");

        put(16'hac7f);
        chk({14'h0000, o_mop}, 16'h0002, "mop up");
        chk({14'h0000, o_sp_invert, o_cds_sel}, 16'h0002, "invert");
        i_tlg20 = 1'b1;
        put(16'hcc7f);
        chk({14'h0000, o_mop}, 16'h0001, "mop down");
        chk({15'h0000, o_cds_sel}, 16'h0001, "cds");
        put(16'hdf7f, 1'b1);
        chk(o_received_word_bits, 16'hdf7f, "word");
        chk({14'h0000, o_mop}, 16'h0001, "unused");
        chk_drive(dcw_pkg::DCW_S_RUN, 1'b1);
        i_tlg20 = 1'b0;
        put(16'h847f);
        chk({13'h0000, o_mop, o_cds_sel}, 16'h0000, "reserved");
        $display("Test setpoint done");

        put(16'h047e);
        chk_drive(dcw_pkg::DCW_S_RAMPDOWN, 1'b1);
        chk_rfg(dcw_pkg::DCW_RAMP_DOWN, 1'b0, 1'b0);
        i_standstill = 1'b1;
        wait_cycles(3);
        chk_drive(dcw_pkg::DCW_S_READY_ON, 1'b0);
        i_standstill = 1'b0;
        put(16'h047f);
        put(16'h047b);
        chk_drive(dcw_pkg::DCW_S_QUICK, 1'b1);
        chk_rfg(dcw_pkg::DCW_RAMP_QUICK, 1'b0, 1'b0);
        i_standstill = 1'b1;
        wait_cycles(3);
        chk_drive(dcw_pkg::DCW_S_INHIBIT, 1'b0);
        i_standstill = 1'b0;
        $display("Test stops done");

        put(16'h047e);
        put(16'h047f);
        put(16'h047d);
        chk({15'h0000, o_pulse_en}, 16'h0000, "coast");
        chk({15'h0000, o_rfg.zero}, 16'h0001, "coast zero");
        put(16'h047e);
        put(16'h047f);
        put(16'h0477);
        chk_drive(dcw_pkg::DCW_S_READY, 1'b0);
        $display("Test coast done");

        i_fault = 1'b1;
        wait_cycles(3);
        chk_drive(dcw_pkg::DCW_S_FAULT, 1'b0);
        i_fault = 1'b0;
        put(16'h04f7);
        chk(16'(acks), 16'h0001, "ack");
        chk_drive(dcw_pkg::DCW_S_INHIBIT, 1'b0);
        put(16'h04f7);
        chk(16'(acks), 16'h0000, "repeat ack");
        put(16'h0476);
        i_fault = 1'b1;
        wait_cycles(3);
        i_fault = 1'b0;
        put(16'h04f6);
        chk(16'(acks), 16'h0001, "ack off");
        chk_drive(dcw_pkg::DCW_S_READY_ON, 1'b0);
        $display("Test fault done");

        give_verdict();
    end
endmodule // test_dcw_decoder

//--- hw/dcw_cfg.svh
// Bit positions, widths and reset values of the drive command word decoder
`ifndef DCW_CFG_SVH
`define DCW_CFG_SVH

`define DCW_WORD_W       16
`define DCW_WORD_RST     16'h0000

`define DCW_BIT_ON       0
`define DCW_BIT_COAST    1
`define DCW_BIT_QSTOP    2
`define DCW_BIT_ENOP     3
`define DCW_BIT_RFG_EN   4
`define DCW_BIT_RFG_RUN  5
`define DCW_BIT_SP_EN    6
`define DCW_BIT_ACK      7
`define DCW_BIT_REMOTE   10
`define DCW_BIT_REVERSE  11
`define DCW_BIT_MOP_UP   13
`define DCW_BIT_MOP_DN   14
`define DCW_BIT_CDS      15

`endif

//--- hw/dcw_decoder.sv
// Drive command word decoder: on/off sequencing, ramp and setpoint commands
`include "dcw_cfg.svh"

module dcw_decoder #(
    parameter int W = `DCW_WORD_W
) (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_word_valid,
    input  wire logic [W-1:0]          i_word,
    input  wire logic                  i_tlg20,
    input  wire logic                  i_fault,
    input  wire logic                  i_standstill,
    output dcw_pkg::dcw_state_t        o_drive_state,
    output logic                       o_pulse_en,
    output dcw_pkg::dcw_rfg_ctrl_t     o_rfg,
    output logic                       o_sp_invert,
    output dcw_pkg::dcw_mop_t          o_mop,
    output logic                       o_cds_sel,
    output logic                       o_fault_ack,
    output logic                       o_remote_ctrl,
    output logic [W-1:0]               o_received_word_bits
);

    // Switch-on needs neither coast stop nor quick stop pending
    function automatic logic run_ok(input logic [W-1:0] w);
        run_ok = w[`DCW_BIT_COAST] & w[`DCW_BIT_QSTOP];
    endfunction

    logic [W-1:0]           cmd_w;
    logic [W-1:0]           cmd_rise;
    logic                   word_load;

    dcw_pkg::dcw_state_t    state_r;
    dcw_pkg::dcw_state_t    state_nxt;
    logic                   pulse_r;
    logic                   pulse_nxt;
    dcw_pkg::dcw_rfg_ctrl_t rfg_r;
    dcw_pkg::dcw_rfg_ctrl_t rfg_nxt;
    logic                   invert_r;
    logic                   invert_nxt;
    dcw_pkg::dcw_mop_t      mop_r;
    dcw_pkg::dcw_mop_t      mop_nxt;
    logic                   mop_map_r;
    logic                   mop_map_nxt;
    logic                   cds_r;
    logic                   cds_nxt;
    logic                   ack_r;
    logic                   ack_nxt;
    logic                   remote_r;
    logic                   remote_nxt;

    // A word without the remote-control bit leaves the held command untouched
    assign word_load = i_word_valid & i_word[`DCW_BIT_REMOTE];

    dcw_edge #(
        .W (W)
    ) u_edge (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (word_load),
        .i_word    (i_word),
        .o_word    (cmd_w),
        .o_rise    (cmd_rise)
    );

    // Bits 8, 9 and 12 are never read below

    // On/off sequencing
    always_comb
    begin
        state_nxt = state_r;
        if (!cmd_w[`DCW_BIT_COAST])
        begin
            state_nxt = dcw_pkg::DCW_S_INHIBIT;
        end
        else if (i_fault)
        begin
            state_nxt = dcw_pkg::DCW_S_FAULT;
        end
        else
        begin
            unique case (state_r)
                dcw_pkg::DCW_S_INHIBIT:
                begin
                    if (!cmd_w[`DCW_BIT_ON] && run_ok(cmd_w))
                        state_nxt = dcw_pkg::DCW_S_READY_ON;
                end
                dcw_pkg::DCW_S_READY_ON:
                begin
                    if (cmd_rise[`DCW_BIT_ON] && run_ok(cmd_w))
                        state_nxt = cmd_w[`DCW_BIT_ENOP] ? dcw_pkg::DCW_S_RUN : dcw_pkg::DCW_S_READY;
                end
                dcw_pkg::DCW_S_READY:
                begin
                    if (!cmd_w[`DCW_BIT_ON])
                        state_nxt = dcw_pkg::DCW_S_READY_ON;
                    else if (!cmd_w[`DCW_BIT_QSTOP])
                        state_nxt = dcw_pkg::DCW_S_INHIBIT;
                    else if (cmd_w[`DCW_BIT_ENOP])
                        state_nxt = dcw_pkg::DCW_S_RUN;
                end
                dcw_pkg::DCW_S_RUN:
                begin
                    if (!cmd_w[`DCW_BIT_ENOP])
                        state_nxt = dcw_pkg::DCW_S_READY;
                    else if (!cmd_w[`DCW_BIT_QSTOP])
                        state_nxt = dcw_pkg::DCW_S_QUICK;
                    else if (!cmd_w[`DCW_BIT_ON])
                        state_nxt = dcw_pkg::DCW_S_RAMPDOWN;
                end
                dcw_pkg::DCW_S_RAMPDOWN:
                begin
                    if (!cmd_w[`DCW_BIT_ENOP])
                        state_nxt = dcw_pkg::DCW_S_READY_ON;
                    else if (!cmd_w[`DCW_BIT_QSTOP])
                        state_nxt = dcw_pkg::DCW_S_QUICK;
                    else if (i_standstill)
                        state_nxt = dcw_pkg::DCW_S_READY_ON;
                    else if (cmd_rise[`DCW_BIT_ON])
                        state_nxt = dcw_pkg::DCW_S_RUN;
                end
                dcw_pkg::DCW_S_QUICK:
                begin
                    if (!cmd_w[`DCW_BIT_ENOP] || i_standstill)
                        state_nxt = dcw_pkg::DCW_S_INHIBIT;
                end
                dcw_pkg::DCW_S_FAULT:
                begin
                    // ON still held after the acknowledge forces a fresh OFF/ON cycle
                    if (cmd_rise[`DCW_BIT_ACK])
                        state_nxt = (cmd_w[`DCW_BIT_ON] || !run_ok(cmd_w)) ?
                                    dcw_pkg::DCW_S_INHIBIT : dcw_pkg::DCW_S_READY_ON;
                end
                default:
                begin
                    state_nxt = dcw_pkg::DCW_S_INHIBIT;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            state_r <= dcw_pkg::DCW_S_INHIBIT;
        else
            state_r <= state_nxt;
    end

    // Power stage and ramp generator commands
    always_comb
    begin
        pulse_nxt = (state_nxt == dcw_pkg::DCW_S_RUN) ||
                    (state_nxt == dcw_pkg::DCW_S_RAMPDOWN) ||
                    (state_nxt == dcw_pkg::DCW_S_QUICK);
        unique case (state_nxt)
            dcw_pkg::DCW_S_RUN:
                rfg_nxt.ramp_sel = cmd_w[`DCW_BIT_SP_EN] ?
                                   dcw_pkg::DCW_RAMP_UP : dcw_pkg::DCW_RAMP_DOWN;
            dcw_pkg::DCW_S_RAMPDOWN:
                rfg_nxt.ramp_sel = dcw_pkg::DCW_RAMP_DOWN;
            dcw_pkg::DCW_S_QUICK:
                rfg_nxt.ramp_sel = dcw_pkg::DCW_RAMP_QUICK;
            default:
                rfg_nxt.ramp_sel = dcw_pkg::DCW_RAMP_HOLD;
        endcase
        // Without pulses the ramp output is meaningless, so it is held at zero
        rfg_nxt.zero   = !cmd_w[`DCW_BIT_RFG_EN] || !pulse_nxt;
        rfg_nxt.freeze = !cmd_w[`DCW_BIT_RFG_RUN];
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            pulse_r <= 1'b0;
            rfg_r   <= '{ramp_sel: dcw_pkg::DCW_RAMP_HOLD, zero: 1'b1, freeze: 1'b0};
        end
        else
        begin
            pulse_r <= pulse_nxt;
            rfg_r   <= rfg_nxt;
        end
    end

    // Setpoint, potentiometer, command set and acknowledge
    always_comb
    begin
        invert_nxt  = cmd_w[`DCW_BIT_REVERSE];
        // Entering telegram 20 keeps whatever use bits 13/14 had before
        mop_map_nxt = !i_tlg20 | mop_map_r;
        mop_nxt.up   = mop_map_nxt & cmd_w[`DCW_BIT_MOP_UP];
        mop_nxt.down = mop_map_nxt & cmd_w[`DCW_BIT_MOP_DN];
        cds_nxt     = i_tlg20 & cmd_w[`DCW_BIT_CDS];
        ack_nxt     = cmd_rise[`DCW_BIT_ACK];
        remote_nxt  = i_word_valid ? i_word[`DCW_BIT_REMOTE] : remote_r;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            invert_r  <= 1'b0;
            mop_map_r <= 1'b0;
            mop_r     <= '0;
            cds_r     <= 1'b0;
            ack_r     <= 1'b0;
            remote_r  <= 1'b0;
        end
        else
        begin
            invert_r  <= invert_nxt;
            mop_map_r <= mop_map_nxt;
            mop_r     <= mop_nxt;
            cds_r     <= cds_nxt;
            ack_r     <= ack_nxt;
            remote_r  <= remote_nxt;
        end
    end

    assign o_drive_state        = state_r;
    assign o_pulse_en           = pulse_r;
    assign o_rfg                = rfg_r;
    assign o_sp_invert          = invert_r;
    assign o_mop                = mop_r;
    assign o_cds_sel            = cds_r;
    assign o_fault_ack          = ack_r;
    assign o_remote_ctrl        = remote_r;
    assign o_received_word_bits = cmd_w;

    default clocking dcw_cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    chk_coast_cuts_drive: assert property (
        !cmd_w[`DCW_BIT_COAST] |=> !o_pulse_en && o_drive_state == dcw_pkg::DCW_S_INHIBIT)
        else $error("coast stop did not cut drive");

    chk_enop_gates_pulses: assert property (
        !cmd_w[`DCW_BIT_ENOP] |=> !o_pulse_en)
        else $error("pulses enabled without enable operation");

    chk_rfg_forced_zero: assert property (
        !cmd_w[`DCW_BIT_RFG_EN] |=> o_rfg.zero)
        else $error("ramp output not forced to zero");

    chk_rfg_frozen: assert property (
        !o_pulse_en || o_rfg.freeze == !$past(cmd_w[`DCW_BIT_RFG_RUN]))
        else $error("ramp freeze does not follow bit 5");

    chk_quick_ramp_state: assert property (
        (o_rfg.ramp_sel == dcw_pkg::DCW_RAMP_QUICK) == (o_drive_state == dcw_pkg::DCW_S_QUICK))
        else $error("quick ramp and quick stop state disagree");

    chk_off_ramps_down: assert property (
        (state_r == dcw_pkg::DCW_S_RUN && !cmd_w[`DCW_BIT_ON] && run_ok(cmd_w) &&
         cmd_w[`DCW_BIT_ENOP] && !i_fault)
        |=> o_drive_state == dcw_pkg::DCW_S_RAMPDOWN && o_rfg.ramp_sel == dcw_pkg::DCW_RAMP_DOWN
            && o_pulse_en)
        else $error("normal stop did not start ramp down");

    chk_on_edge_runs: assert property (
        (state_r == dcw_pkg::DCW_S_READY_ON && cmd_rise[`DCW_BIT_ON] && !i_fault)
        |=> o_pulse_en == (run_ok($past(cmd_w)) && $past(cmd_w[`DCW_BIT_ENOP])))
        else $error("switch-on edge handled wrongly");

    chk_setpoint_ramp_up: assert property (
        (state_nxt == dcw_pkg::DCW_S_RUN)
        |=> o_rfg.ramp_sel == ($past(cmd_w[`DCW_BIT_SP_EN]) ? dcw_pkg::DCW_RAMP_UP : dcw_pkg::DCW_RAMP_DOWN))
        else $error("ramp direction does not follow bit 6");

    chk_ack_inhibits: assert property (
        (state_r == dcw_pkg::DCW_S_FAULT && cmd_rise[`DCW_BIT_ACK] && cmd_w[`DCW_BIT_ON] && !i_fault)
        |=> o_drive_state == dcw_pkg::DCW_S_INHIBIT && o_fault_ack)
        else $error("acknowledge with ON held did not inhibit");

    chk_ignored_word: assert property (
        (i_word_valid && !i_word[`DCW_BIT_REMOTE]) |=> $stable(cmd_w) && !o_remote_ctrl)
        else $error("word without remote control was taken");

    chk_invert_follows: assert property (
        ##1 o_sp_invert == $past(cmd_w[`DCW_BIT_REVERSE]))
        else $error("setpoint invert does not follow bit 11");

    chk_mop_unmapped: assert property (
        (i_tlg20 && !mop_map_r) |=> !o_mop.up && !o_mop.down)
        else $error("potentiometer moved without prior assignment");

    chk_cds_reserved: assert property (
        !i_tlg20 |=> !o_cds_sel)
        else $error("command set selected outside telegram 20");

    chk_edge_once: assert property (
        cmd_rise[`DCW_BIT_ON] |=> !cmd_rise[`DCW_BIT_ON])
        else $error("switch-on edge seen twice");

    chk_quick_stop_entry: assert property (
        (state_r == dcw_pkg::DCW_S_RUN && cmd_w[`DCW_BIT_COAST] && cmd_w[`DCW_BIT_ENOP] &&
         !cmd_w[`DCW_BIT_QSTOP] && !i_fault)
        |=> o_drive_state == dcw_pkg::DCW_S_QUICK && o_rfg.ramp_sel == dcw_pkg::DCW_RAMP_QUICK && o_pulse_en)
        else $error("quick stop did not start quick ramp");

    chk_mop_follows: assert property (
        !i_tlg20 |=> o_mop.up == $past(cmd_w[`DCW_BIT_MOP_UP]) && o_mop.down == $past(cmd_w[`DCW_BIT_MOP_DN]))
        else $error("potentiometer commands do not follow bits 13 and 14");

    chk_remote_follows: assert property (
        i_word_valid |=> o_remote_ctrl == $past(i_word[`DCW_BIT_REMOTE]))
        else $error("remote control flag does not follow bit 10");

    chk_word_taken: assert property (
        (i_word_valid && i_word[`DCW_BIT_REMOTE]) |=> o_received_word_bits == $past(i_word))
        else $error("accepted word not registered");

    chk_cds_follows: assert property (
        i_tlg20 |=> o_cds_sel == $past(cmd_w[`DCW_BIT_CDS]))
        else $error("command set select does not follow bit 15");

    chk_ack_single_pulse: assert property (
        o_fault_ack |=> !o_fault_ack)
        else $error("fault acknowledge longer than one cycle");

    chk_ack_releases: assert property (
        (state_r == dcw_pkg::DCW_S_FAULT && cmd_rise[`DCW_BIT_ACK] && !cmd_w[`DCW_BIT_ON] && run_ok(cmd_w) &&
         !i_fault)
        |=> o_drive_state == dcw_pkg::DCW_S_READY_ON && o_fault_ack)
        else $error("acknowledge with ON low did not release");

endmodule // dcw_decoder

//--- hw/dcw_edge.sv
// Received command word register with per-bit rising edge pulses
`include "dcw_cfg.svh"

module dcw_edge #(
    parameter int W = `DCW_WORD_W
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_word,
    output logic      [W-1:0] o_word,
    output logic      [W-1:0] o_rise
);

    logic [W-1:0] word_r;
    logic [W-1:0] word_nxt;
    logic [W-1:0] rise_r;
    logic [W-1:0] rise_nxt;

    // Edges are taken against the previous word, so one word gives one pulse
    for (genvar b = 0; b < W; b++)
    begin : g_bit
        always_comb
        begin
            word_nxt[b] = i_load ? i_word[b] : word_r[b];
            rise_nxt[b] = i_load & i_word[b] & ~word_r[b];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            word_r <= W'(`DCW_WORD_RST);
            rise_r <= '0;
        end
        else
        begin
            word_r <= word_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign o_word = word_r;
    assign o_rise = rise_r;

endmodule // dcw_edge

//--- hw/dcw_pkg.sv
// Types shared by the drive command word decoder
package dcw_pkg;

    typedef enum logic [2:0] {
        DCW_S_INHIBIT  = 3'b000,
        DCW_S_READY_ON = 3'b001,
        DCW_S_READY    = 3'b010,
        DCW_S_RUN      = 3'b011,
        DCW_S_RAMPDOWN = 3'b100,
        DCW_S_QUICK    = 3'b101,
        DCW_S_FAULT    = 3'b110
    } dcw_state_t;

    typedef enum logic [1:0] {
        DCW_RAMP_HOLD  = 2'b00,
        DCW_RAMP_UP    = 2'b01,
        DCW_RAMP_DOWN  = 2'b10,
        DCW_RAMP_QUICK = 2'b11
    } dcw_ramp_t;

    typedef struct packed {
        dcw_ramp_t ramp_sel;
        logic      zero;
        logic      freeze;
    } dcw_rfg_ctrl_t;

    typedef struct packed {
        logic up;
        logic down;
    } dcw_mop_t;

endpackage
